// *** hw/pic_pin_interrupt_control.sv ***
// Module: external pin interrupt latches, enables, acknowledges and vectoring
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - Software writes never set or clear the high-pin edge pending flag directly.
// - Falling edge on port pin seven sets high-pin edge pending flag.
// - High-pin pending with its enable keeps the external request asserted.
// - Reset clears the high-pin edge pending flag.
// - Only acknowledge-one clears high-pin pending; vector fetch leaves it.
// - Software writes never change the main external pending flag directly.
// - Main pending with main enable keeps the external request asserted.
// - Reset clears the main external pending flag.
// - External vector fetch clears main pending only if high-pin enable clear.
// - With high-pin enable set, only main acknowledge clears main pending.
// - Main acknowledge clears main latch unless a same-cycle set wins; active level keeps it set.
// - High-pin enable gates its flag; reset clears it; stop/wait leave it.
// - Main enable gates main pending; reset sets it to one.
// - Stop or wait forces the main enable to one.
// - Optional low pin group is OR'ed with the dedicated interrupt pin.
// - Main enable also gates the low pin group interrupts.
// - Pins interrupt regardless of their input or output direction.
// - Branch-on-level tests only the dedicated pin level.
// - Multi-function timer event requests vector 0FF8 when mask clear.
// - Wide timer event requests vector 0FF6 when mask clear.
// - Main latch sets on pin fall, group rise, or active level option.
// - Both external sources vector to 0FFA.
// - Acknowledge bits read zero; writing zero leaves latches unchanged.
// - Unused control/status bits read as zero.
module pic_pin_interrupt_control
  import pic_pkg::*;
#(
  parameter int GROUP_WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins (asynchronous)
  input wire logic irq_pin_n,
  input wire logic [GROUP_WIDTH-1:0] low_port_pin_group,
  input wire logic port_pin_seven,
  // Build-time options, static after reset
  input wire logic group_option,
  input wire logic level_option,
  // CPU core side
  input wire logic cpu_interrupt_mask,
  input wire logic low_power_entry,
  input wire logic vector_fetch,
  input wire logic [11:0] vector_fetch_addr,
  input wire logic mft_event,
  input wire logic wide_timer_event,
  output logic external_request,
  output logic interrupt_request,
  output logic [11:0] interrupt_vector,
  output logic branch_if_pin_high,
  output logic branch_if_pin_low
);

  // ==========================================================
  // Elaboration check
  if (GROUP_WIDTH < 1 || GROUP_WIDTH > 8) begin : g_bad_width
    $error("GROUP_WIDTH must lie in 1..8");
  end

  // ==========================================================
  // State
  typedef struct packed {
    pic_bus_state_type bus_state;
    logic [31:0] readdata;
    pic_pin_sync_type irq_pin;
    pic_pin_sync_type hp_pin;
    pic_pin_sync_type [GROUP_WIDTH-1:0] grp_pin;
    logic hp_pending;
    logic main_pending;
    logic hp_enable;
    logic main_enable;
    logic [11:0] vector;
    logic ext_req;
    logic any_req;
    logic pin_high;
  } pic_state_type;

  pic_state_type state_q;
  pic_state_type state_d;

  // Filtered pin level: changes only when stages two and three agree
  function automatic pic_pin_sync_type pic_sync_step(input pic_pin_sync_type cur, input logic pin);
    pic_pin_sync_type nxt;
    nxt = cur;
    nxt.sync = {cur.sync[1:0], pin};
    if (cur.sync[1] == cur.sync[2]) begin
      nxt.level = cur.sync[2];
    end
    return nxt;
  endfunction

  pic_bus_req_type req;
  assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

  always_comb begin
    logic irq_fall;
    logic hp_fall;
    logic grp_rise;
    logic grp_high;
    logic main_set;
    logic wr_cs;
    logic [7:0] cs_read;
    irq_fall = 1'b0;
    hp_fall = 1'b0;
    grp_rise = 1'b0;
    grp_high = 1'b0;
    main_set = 1'b0;
    wr_cs = 1'b0;
    cs_read = 8'h00;
    state_d = state_q;

    // ========================================================
    // Pin synchronisers and edge detection on filtered levels
    state_d.irq_pin = pic_sync_step(state_q.irq_pin, irq_pin_n);
    state_d.hp_pin = pic_sync_step(state_q.hp_pin, port_pin_seven);
    for (int i = 0; i < GROUP_WIDTH; i++) begin
      state_d.grp_pin[i] = pic_sync_step(state_q.grp_pin[i], low_port_pin_group[i]);
      grp_rise = grp_rise | (state_d.grp_pin[i].level & ~state_q.grp_pin[i].level);
      grp_high = grp_high | state_q.grp_pin[i].level;
    end
    irq_fall = state_q.irq_pin.level & ~state_d.irq_pin.level;
    hp_fall = state_q.hp_pin.level & ~state_d.hp_pin.level;

    // Group only counts when the option is built in
    main_set = irq_fall | (group_option & grp_rise);
    if (level_option) begin
      main_set = main_set | ~state_q.irq_pin.level | (group_option & grp_high);
    end

    // ========================================================
    // Bus slave: one wait cycle, then answer
    wr_cs = 1'b0;
    unique case (state_q.bus_state)
      PIC_BUS_IDLE: begin
        if (req.read || req.write) begin
          state_d.bus_state = PIC_BUS_DONE;
        end
      end
      PIC_BUS_DONE: begin
        state_d.bus_state = PIC_BUS_IDLE;
        wr_cs = req.write && req.address == PIC_ADDR_CTRL_STATUS;
      end
    endcase

    // ========================================================
    // Latches: acknowledge clears, but a same-cycle set wins
    if (wr_cs && req.writedata[PIC_BIT_HP_ACK]) begin
      state_d.hp_pending = 1'b0;
    end
    if (hp_fall) begin
      state_d.hp_pending = 1'b1;
    end

    if (wr_cs && req.writedata[PIC_BIT_MAIN_ACK]) begin
      state_d.main_pending = 1'b0;
    end
    if (vector_fetch && vector_fetch_addr == PIC_VEC_EXTERNAL && !state_q.hp_enable) begin
      state_d.main_pending = 1'b0;
    end
    if (main_set) begin
      state_d.main_pending = 1'b1;
    end
    // Pending bits are never loaded from write data

    if (wr_cs) begin
      state_d.hp_enable = req.writedata[PIC_BIT_HP_ENABLE];
      state_d.main_enable = req.writedata[PIC_BIT_MAIN_ENABLE];
    end
    if (low_power_entry) begin
      state_d.main_enable = 1'b1;
    end

    // ========================================================
    // Requests and vectoring, highest vector first
    state_d.ext_req = (state_q.hp_pending & state_q.hp_enable) |
                      (state_q.main_pending & state_q.main_enable);
    state_d.any_req = ~cpu_interrupt_mask & (state_d.ext_req | mft_event | wide_timer_event);
    if (state_d.ext_req) begin
      state_d.vector = PIC_VEC_EXTERNAL;
    end else if (mft_event) begin
      state_d.vector = PIC_VEC_MFT;
    end else if (wide_timer_event) begin
      state_d.vector = PIC_VEC_WIDE_TIMER;
    end
    // Dedicated pin only, not the OR with the group
    state_d.pin_high = state_q.irq_pin.level;

    // ========================================================
    // Read data, captured in the wait cycle, shown with the answer
    cs_read = 8'h00;
    cs_read[PIC_BIT_HP_ENABLE] = state_q.hp_enable;
    cs_read[PIC_BIT_MAIN_ENABLE] = state_q.main_enable;
    cs_read[PIC_BIT_HP_PENDING] = state_q.hp_pending;
    cs_read[PIC_BIT_MAIN_PENDING] = state_q.main_pending;
    if (state_q.bus_state == PIC_BUS_IDLE && req.read) begin
      unique case (req.address)
        PIC_ADDR_CTRL_STATUS: state_d.readdata = {24'h000000, cs_read};
        PIC_ADDR_OPTIONS: state_d.readdata = {30'h00000000, level_option, group_option};
        PIC_ADDR_PIN_LEVEL: state_d.readdata = {30'h00000000, state_q.hp_pin.level, state_q.irq_pin.level};
        default: state_d.readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= '0;
      state_q.bus_state <= PIC_BUS_IDLE;
      state_q.irq_pin <= '{sync: PIC_RST_SYNC, level: 1'b1};
      state_q.hp_pin <= '{sync: PIC_RST_SYNC, level: 1'b1};
      state_q.hp_pending <= PIC_RST_HP_PENDING;
      state_q.main_pending <= PIC_RST_MAIN_PENDING;
      state_q.hp_enable <= PIC_RST_HP_ENABLE;
      state_q.main_enable <= PIC_RST_MAIN_ENABLE;
      state_q.vector <= PIC_VEC_EXTERNAL;
      state_q.pin_high <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest = (avs_read | avs_write) & (state_q.bus_state != PIC_BUS_DONE);
  assign avs_readdata = state_q.readdata;
  assign external_request = state_q.ext_req;
  assign interrupt_request = state_q.any_req;
  assign interrupt_vector = state_q.vector;
  assign branch_if_pin_high = state_q.pin_high;
  assign branch_if_pin_low = ~state_q.pin_high;

endmodule

// *** hw/pic_pkg.sv ***
// Package: constants and carrier types for the pin interrupt control block
package pic_pkg;

  // ==========================================================
  // Register map (Avalon word addresses)
  localparam logic [1:0] PIC_ADDR_CTRL_STATUS = 2'h0;
  localparam logic [1:0] PIC_ADDR_OPTIONS = 2'h1;
  localparam logic [1:0] PIC_ADDR_PIN_LEVEL = 2'h2;

  // ==========================================================
  // Control/status field positions
  localparam int PIC_BIT_HP_ACK = 0;
  localparam int PIC_BIT_MAIN_ACK = 1;
  localparam int PIC_BIT_HP_ENABLE = 4;
  localparam int PIC_BIT_MAIN_ENABLE = 5;
  localparam int PIC_BIT_HP_PENDING = 6;
  localparam int PIC_BIT_MAIN_PENDING = 7;

  // Options register field positions
  localparam int PIC_BIT_OPT_GROUP = 0;
  localparam int PIC_BIT_OPT_LEVEL = 1;

  // ==========================================================
  // Reset values
  localparam logic PIC_RST_HP_PENDING = 1'b0;
  localparam logic PIC_RST_MAIN_PENDING = 1'b0;
  localparam logic PIC_RST_HP_ENABLE = 1'b0;
  localparam logic PIC_RST_MAIN_ENABLE = 1'b1;
  localparam logic [2:0] PIC_RST_SYNC = 3'h7;

  // ==========================================================
  // Vector addresses
  localparam logic [11:0] PIC_VEC_EXTERNAL = 12'hFFA;
  localparam logic [11:0] PIC_VEC_MFT = 12'hFF8;
  localparam logic [11:0] PIC_VEC_WIDE_TIMER = 12'hFF6;

  // Bus response timing: one wait cycle on every access
  localparam int PIC_BUS_WAIT_CYCLES = 1;

  // ==========================================================
  // Avalon request carrier
  typedef struct packed {
    logic [1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pic_bus_req_type;

  // Three-stage pin synchroniser for one pin
  typedef struct packed {
    logic [2:0] sync;
    logic level;
  } pic_pin_sync_type;

  // Bus handshake state, one-hot
  typedef enum logic [1:0] {
    PIC_BUS_IDLE = 2'b01,
    PIC_BUS_DONE = 2'b10
  } pic_bus_state_type;

endpackage

// *** sim/pic_cpu_model.sv ***
// Partner: CPU interrupt sequencer that fetches vectors while a request stands
`timescale 1ns/1ps
module pic_cpu_model #(
  parameter int DELAY = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic interrupt_request,
  input wire logic [11:0] interrupt_vector,
  output logic vector_fetch,
  output logic [11:0] vector_fetch_addr
);
  int cnt;
  // Keeps re-entering service while the request stands
  always_ff @(posedge mclk) begin
    vector_fetch <= 1'b0;
    if (rst || !interrupt_request) begin
      cnt <= 0;
      vector_fetch_addr <= 12'h000;
    end else if (cnt == DELAY) begin
      vector_fetch <= 1'b1;
      vector_fetch_addr <= interrupt_vector;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** sim/pic_properties.sv ***
// Checker: concurrent properties on the pin interrupt control ports
`timescale 1ns/1ps
module pic_properties
  import pic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic cpu_interrupt_mask,
  input wire logic vector_fetch,
  input wire logic mft_event,
  input wire logic irq_pin_n,
  input wire logic external_request,
  input wire logic interrupt_request,
  input wire logic [11:0] interrupt_vector,
  input wire logic branch_if_pin_high,
  input wire logic branch_if_pin_low
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Sequences
  sequence s_new_req;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_quiet;
    !vector_fetch && !$past(vector_fetch) && !avs_write && !$past(avs_write);
  endsequence
  // ==========================================================
  // Properties
  a_bus_one_wait: assert property (s_new_req |-> s_answer)
    else $error("bus answer not after one wait cycle");
  a_request_holds: assert property ((external_request and s_quiet) |=> external_request)
    else $error("external request dropped without clear");
  a_mask_blocks: assert property (cpu_interrupt_mask |=> !interrupt_request)
    else $error("request passed while masked");
  a_timer_request: assert property (mft_event && !cpu_interrupt_mask |=> interrupt_request)
    else $error("timer event not requested");
  a_timer_vector: assert property ($past(mft_event) && !$past(external_request) && !external_request
    |-> interrupt_vector == PIC_VEC_MFT)
    else $error("timer vector wrong");
  a_ext_vector: assert property (external_request [*2] |-> interrupt_vector == PIC_VEC_EXTERNAL)
    else $error("external vector wrong");
  a_branch_level: assert property (!irq_pin_n [*7] |-> branch_if_pin_low)
    else $error("branch level does not follow pin");
  a_branch_pair: assert property (branch_if_pin_low == !branch_if_pin_high)
    else $error("branch outputs disagree");
endmodule

bind pic_pin_interrupt_control pic_properties u_props (.mclk(mclk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cpu_interrupt_mask(cpu_interrupt_mask),
  .vector_fetch(vector_fetch), .mft_event(mft_event), .irq_pin_n(irq_pin_n),
  .external_request(external_request), .interrupt_request(interrupt_request),
  .interrupt_vector(interrupt_vector), .branch_if_pin_high(branch_if_pin_high),
  .branch_if_pin_low(branch_if_pin_low));

// *** sim/pin_interrupt_control_tb_top.sv ***
// Testbench: register bus, pin sources, acknowledges and timer vectoring
`timescale 1ns/1ps
module pin_interrupt_control_tb_top;
  import pic_pkg::*;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, irq_pin_n, port_pin_seven, group_option;
  logic level_option, cpu_interrupt_mask, low_power_entry, vector_fetch, mft_event, wide_timer_event;
  logic external_request, interrupt_request, branch_if_pin_high, branch_if_pin_low;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] low_port_pin_group;
  logic [11:0] vector_fetch_addr, interrupt_vector;
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] rows [4] = '{16'hFF30, 16'h0000, 16'h1010, 16'h2020};
  pic_pin_interrupt_control u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_pin_n(irq_pin_n), .low_port_pin_group(low_port_pin_group),
    .port_pin_seven(port_pin_seven), .group_option(group_option), .level_option(level_option),
    .cpu_interrupt_mask(cpu_interrupt_mask), .low_power_entry(low_power_entry), .vector_fetch(vector_fetch),
    .vector_fetch_addr(vector_fetch_addr), .mft_event(mft_event), .wide_timer_event(wide_timer_event),
    .external_request(external_request), .interrupt_request(interrupt_request),
    .interrupt_vector(interrupt_vector), .branch_if_pin_high(branch_if_pin_high),
    .branch_if_pin_low(branch_if_pin_low));
  pic_cpu_model u_cpu (.mclk(mclk), .rst(rst), .interrupt_request(interrupt_request),
    .interrupt_vector(interrupt_vector), .vector_fetch(vector_fetch), .vector_fetch_addr(vector_fetch_addr));
  // ==========================================================
  // Tasks
  task automatic summarize();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge; pre-edge values are read
  task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    bus(PIC_ADDR_CTRL_STATUS, 1'b1, d);
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ==========================================================
  // Clock, watchdog, main sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    cyc(3000);
    n_errors++;
    summarize();
  end
  initial begin
    {rst, irq_pin_n, port_pin_seven} = 3'h7;
    {avs_read, avs_write, group_option, level_option, cpu_interrupt_mask} = 5'h0;
    {low_power_entry, mft_event, wide_timer_event, avs_address, avs_writedata} = '0;
    low_port_pin_group = 4'h0;
    cyc(10);
    rst <= 1'b0;
    rd(PIC_ADDR_CTRL_STATUS, 32'h20);
    rd(2'h3, 32'h0);
    foreach (rows[i]) begin
      wr({24'h0, rows[i][15:8]});
      rd(PIC_ADDR_CTRL_STATUS, {24'h0, rows[i][7:0]});
    end
    wr(32'h30);
    port_pin_seven <= 1'b0;
    cyc(8);
    chk({31'h0, external_request}, 32'h1);
    port_pin_seven <= 1'b1;
    cyc(10);
    rd(PIC_ADDR_CTRL_STATUS, 32'h70);
    wr(32'h31);
    rd(PIC_ADDR_CTRL_STATUS, 32'h30);
    irq_pin_n <= 1'b0;
    cyc(18);
    irq_pin_n <= 1'b1;
    rd(PIC_ADDR_CTRL_STATUS, 32'hB0);
    wr(32'h32);
    rd(PIC_ADDR_CTRL_STATUS, 32'h30);
    wr(32'h20);
    cpu_interrupt_mask <= 1'b1;
    irq_pin_n <= 1'b0;
    cyc(8);
    rd(PIC_ADDR_CTRL_STATUS, 32'hA0);
    chk({31'h0, interrupt_request}, 32'h0);
    chk({31'h0, external_request}, 32'h1);
    cpu_interrupt_mask <= 1'b0;
    cyc(10);
    irq_pin_n <= 1'b1;
    rd(PIC_ADDR_CTRL_STATUS, 32'h20);
    wr(32'h10);
    group_option <= 1'b1;
    low_port_pin_group <= 4'h4;
    cyc(8);
    chk({31'h0, external_request}, 32'h0);
    rd(PIC_ADDR_CTRL_STATUS, 32'h90);
    low_power_entry <= 1'b1;
    cyc(1);
    low_power_entry <= 1'b0;
    cyc(8);
    rd(PIC_ADDR_CTRL_STATUS, 32'hB0);
    wr(32'h32);
    low_port_pin_group <= 4'h0;
    rd(PIC_ADDR_CTRL_STATUS, 32'h30);
    mft_event <= 1'b1;
    cyc(4);
    chk({20'h0, interrupt_vector}, {20'h0, PIC_VEC_MFT});
    mft_event <= 1'b0;
    wide_timer_event <= 1'b1;
    cyc(4);
    chk({20'h0, interrupt_vector}, {20'h0, PIC_VEC_WIDE_TIMER});
    wide_timer_event <= 1'b0;
    cyc(4);
    // Level sensing: acknowledge cannot win while the pin is still low
    level_option <= 1'b1;
    irq_pin_n <= 1'b0;
    cyc(8);
    chk({31'h0, branch_if_pin_low}, 32'h1);
    rd(PIC_ADDR_PIN_LEVEL, 32'h2);
    rd(PIC_ADDR_OPTIONS, 32'h3);
    wr(32'h32);
    rd(PIC_ADDR_CTRL_STATUS, 32'hB0);
    irq_pin_n <= 1'b1;
    cyc(8);
    wr(32'h32);
    rd(PIC_ADDR_CTRL_STATUS, 32'h30);
    level_option <= 1'b0;
    // Mid-run reset with both latches set
    port_pin_seven <= 1'b0;
    irq_pin_n <= 1'b0;
    cyc(8);
    rd(PIC_ADDR_CTRL_STATUS, 32'hF0);
    port_pin_seven <= 1'b1;
    irq_pin_n <= 1'b1;
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    chk({31'h0, external_request}, 32'h0);
    rd(PIC_ADDR_CTRL_STATUS, 32'h20);
    summarize();
  end
endmodule
